/* hdl/crc_unit_pkg.sv */
package crc_unit_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int CRC_W     = 16;
  localparam int REG_W     = 16;
  localparam int ADDR_W    = 6;
  localparam int WORD_W    = 32;
  localparam int MAP_WORDS = 37;
  localparam int MAP_BITS  = MAP_WORDS * REG_W;
  localparam int CNT_W     = 10;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_MAP_FIRST  = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_MAP_LAST   = 6'h26;
  localparam logic [ADDR_W-1:0] ADDR_MODE       = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_REGMAP_CHECKSUM_VALUE = 6'h3e;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int MODE_CRC_TYPE_BIT    = 11;
  localparam int MODE_RX_CRC_EN_BIT   = 12;
  localparam int MODE_REG_CRC_EN_BIT  = 13;
  localparam int STATUS_COMM_ERR_BIT  = 12;
  localparam int STATUS_MAP_CHG_BIT   = 13;
  localparam logic [REG_W-1:0] MAP_RESET   = 16'h0000;
  localparam logic [REG_W-1:0] READ_ZERO   = 16'h0000;

  // ************************************************************
  // checksum constants
  // ************************************************************
  localparam logic [CRC_W-1:0] POLY_CCITT = 16'h1021;
  localparam logic [CRC_W-1:0] POLY_ANSI  = 16'h8005;
  localparam logic [CRC_W-1:0] CRC_SEED   = 16'hffff;
  localparam logic [CNT_W-1:0] MAP_LAST_BIT = 10'h24f;

  typedef enum logic [2:0] {
    MAP_IDLE  = 3'b001,
    MAP_RUN   = 3'b010,
    MAP_CHECK = 3'b100
  } map_state_e;

  // one frame as seen by the serial shim, all same-clock pulses
  typedef struct packed {
    logic              start;
    logic              word_valid;
    logic [WORD_W-1:0] word;
    logic              crc_valid;
    logic [CRC_W-1:0]  crc;
    logic              frame_end;
    logic              is_register_write_command;
  } rx_frame_s;

  typedef struct packed {
    logic              word_valid;
    logic [WORD_W-1:0] word;
  } tx_frame_s;

endpackage : crc_unit_pkg

/* hdl/crc_unit.sv */
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Function
// RULE_01: check word is 16 bits both directions
// RULE_02: checksum covers all words including padding
// RULE_03: input check enabled by bit, off at reset
// RULE_04: compare received checksum, mismatch is error
// RULE_05: failed check suppresses all but register write
// RULE_06: every checksum error sets communication error flag
// RULE_07: next frame answers like no-operation
// RULE_08: communication error clears when status shifted out
// RULE_09: outgoing frame always ends with checksum
// RULE_10: one type bit selects polynomial everywhere
// RULE_11: polynomials are CCITT and ANSI CRC-16
// RULE_12: frame checksum starts from all ones
// RULE_13: map check bit enables continuous recompute
// RULE_14: map span 02h to 26h, MSB first
// RULE_15: each map pass starts from all ones
// RULE_16: map result 16 bits, readable register
// RULE_17: one bit per clock input period, compare
// RULE_18: changed result sets map-changed flag
// RULE_19: map flag clears on status read or nop
// RULE_20: serial MSB first, no reflection, no inversion
module crc_unit #(
  parameter int WORD_W    = crc_unit_pkg::WORD_W,
  parameter int MAP_WORDS = crc_unit_pkg::MAP_WORDS
) (
  // clock and reset
  input  wire logic                               clock,
  input  wire logic                               rstn,
  // register port
  input  wire logic [crc_unit_pkg::ADDR_W-1:0]    addr,
  input  wire logic [crc_unit_pkg::REG_W-1:0]     wdata,
  input  wire logic                               wr,
  input  wire logic                               rd,
  output logic      [crc_unit_pkg::REG_W-1:0]     rdata,
  // link clock pin
  input  wire logic                               device_clock_input,
  // frame traffic from the serial shim
  input  wire crc_unit_pkg::rx_frame_s            rx,
  input  wire crc_unit_pkg::tx_frame_s            tx,
  input  wire logic                               status_sent,
  input  wire logic                               status_sent_null,
  // results
  output logic                                    cmd_execute,
  output logic                                    cmd_suppress,
  output logic                                    null_response,
  output logic      [crc_unit_pkg::CRC_W-1:0]     tx_crc,
  output logic                                    comm_err,
  output logic                                    map_changed,
  output logic      [crc_unit_pkg::CRC_W-1:0]     regmap_checksum_value
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [crc_unit_pkg::CRC_W-1:0] crc_bit(
    input logic [crc_unit_pkg::CRC_W-1:0] crc_in,
    input logic                           din,
    input logic [crc_unit_pkg::CRC_W-1:0] poly
  );
    logic fb;
    fb = crc_in[crc_unit_pkg::CRC_W-1] ^ din;
    return {crc_in[crc_unit_pkg::CRC_W-2:0], 1'b0} ^ (fb ? poly : '0); // RULE_20
  endfunction : crc_bit

  function automatic logic [crc_unit_pkg::CRC_W-1:0] crc_word(
    input logic [crc_unit_pkg::CRC_W-1:0] crc_in,
    input logic [WORD_W-1:0]              data,
    input logic [crc_unit_pkg::CRC_W-1:0] poly
  );
    logic [crc_unit_pkg::CRC_W-1:0] c;
    c = crc_in;
    // padding bits are part of the word and folded in too
    for (int i = WORD_W - 1; i >= 0; i--) begin // RULE_02
      c = crc_bit(c, data[i], poly);
    end
    return c;
  endfunction : crc_word

  function automatic logic map_hit(input logic [crc_unit_pkg::ADDR_W-1:0] a);
    return (a >= crc_unit_pkg::ADDR_MAP_FIRST) && (a <= crc_unit_pkg::ADDR_MAP_LAST);
  endfunction : map_hit

  // ************************************************************
  // reset release and pin synchroniser
  // ************************************************************
  logic rst_meta_reg;
  logic rst_sync_n;
  logic device_clock_input_meta_reg;
  logic device_clock_input_sync_reg;
  logic device_clock_input_prev_reg;
  logic device_clock_input_rise;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      device_clock_input_meta_reg <= 1'b0;
      device_clock_input_sync_reg <= 1'b0;
      device_clock_input_prev_reg <= 1'b0;
    end else begin
      device_clock_input_meta_reg <= device_clock_input;
      device_clock_input_sync_reg <= device_clock_input_meta_reg;
      device_clock_input_prev_reg <= device_clock_input_sync_reg;
    end
  end

  assign device_clock_input_rise = device_clock_input_sync_reg & ~device_clock_input_prev_reg;

  // ************************************************************
  // writable register space
  // ************************************************************
  logic [crc_unit_pkg::REG_W-1:0]  map_mem [MAP_WORDS];
  logic [crc_unit_pkg::REG_W-1:0]  mode_word;
  logic                            rx_crc_en;
  logic                            map_crc_en;
  logic [crc_unit_pkg::CRC_W-1:0]  poly;
  logic [crc_unit_pkg::ADDR_W-1:0] wr_index;
  logic [crc_unit_pkg::ADDR_W-1:0] rd_index;

  assign mode_word  = map_mem[crc_unit_pkg::ADDR_MODE - crc_unit_pkg::ADDR_MAP_FIRST];
  assign rx_crc_en  = mode_word[crc_unit_pkg::MODE_RX_CRC_EN_BIT];  // RULE_03
  assign map_crc_en = mode_word[crc_unit_pkg::MODE_REG_CRC_EN_BIT]; // RULE_13
  // one select bit drives both frame directions and the map engine
  assign poly = mode_word[crc_unit_pkg::MODE_CRC_TYPE_BIT] ?
                crc_unit_pkg::POLY_ANSI : crc_unit_pkg::POLY_CCITT; // RULE_10 RULE_11
  assign wr_index = addr - crc_unit_pkg::ADDR_MAP_FIRST;
  assign rd_index = addr - crc_unit_pkg::ADDR_MAP_FIRST;

  genvar g;
  generate
    for (g = 0; g < MAP_WORDS; g++) begin : g_map
      always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          map_mem[g] <= crc_unit_pkg::MAP_RESET;
        end else if (wr && map_hit(addr) && (wr_index == g)) begin
          map_mem[g] <= wdata;
        end
      end
    end
  endgenerate

  // ************************************************************
  // frame checksums
  // ************************************************************
  logic [crc_unit_pkg::CRC_W-1:0] rx_crc_reg;
  logic [crc_unit_pkg::CRC_W-1:0] host_crc_reg;
  logic                           host_crc_seen_reg;
  logic [crc_unit_pkg::CRC_W-1:0] tx_crc_reg;
  logic                           frame_err;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_crc_reg <= crc_unit_pkg::CRC_SEED;
    end else if (rx.start) begin
      rx_crc_reg <= crc_unit_pkg::CRC_SEED; // RULE_12
    end else if (rx.word_valid) begin
      rx_crc_reg <= crc_word(rx_crc_reg, rx.word, poly); // RULE_04
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      host_crc_reg      <= crc_unit_pkg::CRC_SEED;
      host_crc_seen_reg <= 1'b0;
    end else if (rx.start) begin
      host_crc_seen_reg <= 1'b0;
    end else if (rx.crc_valid) begin
      host_crc_reg      <= rx.crc; // RULE_01
      host_crc_seen_reg <= 1'b1;
    end
  end

  // a frame that closes without its check word counts as a mismatch
  assign frame_err = rx.frame_end && rx_crc_en &&
                     (!host_crc_seen_reg || (host_crc_reg != rx_crc_reg)); // RULE_04

  // outgoing checksum has no enable at all; the shim appends it last
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_crc_reg <= crc_unit_pkg::CRC_SEED;
    end else if (rx.start) begin
      tx_crc_reg <= crc_unit_pkg::CRC_SEED; // RULE_12
    end else if (tx.word_valid) begin
      tx_crc_reg <= crc_word(tx_crc_reg, tx.word, poly); // RULE_09
    end
  end

  // ************************************************************
  // command gating and error flag
  // ************************************************************
  logic cmd_execute_reg;
  logic cmd_suppress_reg;
  logic null_response_reg;
  logic comm_err_reg;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmd_execute_reg  <= 1'b0;
      cmd_suppress_reg <= 1'b0;
    end else begin
      cmd_execute_reg  <= rx.frame_end && (!frame_err || rx.is_register_write_command); // RULE_05
      cmd_suppress_reg <= frame_err && !rx.is_register_write_command;                     // RULE_05
    end
  end

  // level held for the whole following frame
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      null_response_reg <= 1'b0;
    end else if (rx.frame_end) begin
      null_response_reg <= frame_err; // RULE_07
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      comm_err_reg <= 1'b0;
    end else if (frame_err) begin
      comm_err_reg <= 1'b1; // RULE_06
    end else if (status_sent) begin
      comm_err_reg <= 1'b0; // RULE_08
    end
  end

  // ************************************************************
  // register map checksum engine
  // ************************************************************
  crc_unit_pkg::map_state_e       map_state_reg;
  logic [crc_unit_pkg::CNT_W-1:0] map_bit_cnt_reg;
  logic [crc_unit_pkg::CRC_W-1:0] map_crc_reg;
  logic [crc_unit_pkg::CRC_W-1:0] map_result_reg;
  logic                           map_prev_valid_reg;
  logic                           map_diff;
  logic                           map_bit;
  logic [crc_unit_pkg::REG_W-1:0] map_word;

  assign map_word = map_mem[map_bit_cnt_reg[crc_unit_pkg::CNT_W-1:4]];
  // MSB of the lowest register first, down to LSB of the highest
  assign map_bit  = map_word[4'hf - map_bit_cnt_reg[3:0]]; // RULE_14
  assign map_diff = (map_state_reg == crc_unit_pkg::MAP_CHECK) && map_prev_valid_reg &&
                    (map_crc_reg != map_result_reg);

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      map_state_reg   <= crc_unit_pkg::MAP_IDLE;
      map_bit_cnt_reg <= '0;
      map_crc_reg     <= crc_unit_pkg::CRC_SEED;
    end else begin
      case (map_state_reg)
        crc_unit_pkg::MAP_IDLE: begin
          map_bit_cnt_reg <= '0;
          map_crc_reg     <= crc_unit_pkg::CRC_SEED;
          if (map_crc_en) begin
            map_state_reg <= crc_unit_pkg::MAP_RUN; // RULE_13
          end
        end
        crc_unit_pkg::MAP_RUN: begin
          if (!map_crc_en) begin
            map_state_reg <= crc_unit_pkg::MAP_IDLE;
          end else if (device_clock_input_rise) begin
            map_crc_reg <= crc_bit(map_crc_reg, map_bit, poly); // RULE_17
            if (map_bit_cnt_reg == crc_unit_pkg::MAP_LAST_BIT) begin
              map_state_reg <= crc_unit_pkg::MAP_CHECK;
            end else begin
              map_bit_cnt_reg <= map_bit_cnt_reg + 1'b1;
            end
          end
        end
        crc_unit_pkg::MAP_CHECK: begin
          map_bit_cnt_reg <= '0;
          map_crc_reg     <= crc_unit_pkg::CRC_SEED; // RULE_15
          map_state_reg   <= map_crc_en ? crc_unit_pkg::MAP_RUN : crc_unit_pkg::MAP_IDLE;
        end
        default: begin
          map_state_reg <= crc_unit_pkg::MAP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      map_result_reg     <= crc_unit_pkg::CRC_SEED;
      map_prev_valid_reg <= 1'b0;
    end else if (map_state_reg == crc_unit_pkg::MAP_CHECK) begin
      map_result_reg     <= map_crc_reg; // RULE_16
      map_prev_valid_reg <= 1'b1;
    end else if (map_state_reg == crc_unit_pkg::MAP_IDLE) begin
      map_prev_valid_reg <= 1'b0;
    end
  end

  // ************************************************************
  // status flag and read port
  // ************************************************************
  logic                           map_changed_reg;
  logic                           status_rd;
  logic [crc_unit_pkg::REG_W-1:0] status_word;
  logic [crc_unit_pkg::REG_W-1:0] rdata_reg;

  assign status_rd = rd && (addr == crc_unit_pkg::ADDR_STATUS);

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      map_changed_reg <= 1'b0;
    end else if (map_diff) begin
      map_changed_reg <= 1'b1; // RULE_18
    end else if (status_rd || (status_sent && status_sent_null)) begin
      map_changed_reg <= 1'b0; // RULE_19
    end
  end

  always_comb begin
    status_word = crc_unit_pkg::READ_ZERO;
    status_word[crc_unit_pkg::STATUS_COMM_ERR_BIT] = comm_err_reg;
    status_word[crc_unit_pkg::STATUS_MAP_CHG_BIT]  = map_changed_reg;
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_reg <= crc_unit_pkg::READ_ZERO;
    end else if (!rd) begin
      rdata_reg <= crc_unit_pkg::READ_ZERO;
    end else if (addr == crc_unit_pkg::ADDR_STATUS) begin
      rdata_reg <= status_word;
    end else if (addr == crc_unit_pkg::ADDR_REGMAP_CHECKSUM_VALUE) begin
      rdata_reg <= map_result_reg; // RULE_16
    end else if (map_hit(addr)) begin
      rdata_reg <= map_mem[rd_index];
    end else begin
      rdata_reg <= crc_unit_pkg::READ_ZERO;
    end
  end

  assign rdata                 = rdata_reg;
  assign cmd_execute           = cmd_execute_reg;
  assign cmd_suppress          = cmd_suppress_reg;
  assign null_response         = null_response_reg;
  assign tx_crc                = tx_crc_reg;
  assign comm_err              = comm_err_reg;
  assign map_changed           = map_changed_reg;
  assign regmap_checksum_value = map_result_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_sync_n);

  sequence seq_bit_step;
    (map_state_reg == crc_unit_pkg::MAP_RUN) && map_crc_en && device_clock_input_rise &&
    (map_bit_cnt_reg != crc_unit_pkg::MAP_LAST_BIT);
  endsequence

  sequence seq_pass_end;
    (map_state_reg == crc_unit_pkg::MAP_RUN) && map_crc_en && device_clock_input_rise &&
    (map_bit_cnt_reg == crc_unit_pkg::MAP_LAST_BIT);
  endsequence

  a_register_write_command_always_runs: assert property ( // RULE_05
    rx.frame_end && rx.is_register_write_command |=> cmd_execute_reg && !cmd_suppress_reg)
    else $error("register write not executed");

  a_err_suppresses: assert property ( // RULE_04
    rx.frame_end && rx_crc_en && host_crc_seen_reg && (host_crc_reg != rx_crc_reg) &&
    !rx.is_register_write_command |=> cmd_suppress_reg && !cmd_execute_reg && comm_err_reg)
    else $error("mismatch did not suppress command");

  a_check_off_passes: assert property ( // RULE_03
    rx.frame_end && !rx_crc_en |=> cmd_execute_reg && !cmd_suppress_reg)
    else $error("disabled check blocked a command");

  a_null_follows_err: assert property ( // RULE_07
    frame_err |=> null_response_reg until rx.frame_end)
    else $error("no-operation answer not held");

  a_comm_err_clears: assert property ( // RULE_08
    status_sent && !frame_err |=> !comm_err_reg)
    else $error("error flag not cleared by status output");

  a_tx_seeded: assert property ( // RULE_12
    rx.start |=> tx_crc_reg == crc_unit_pkg::CRC_SEED && rx_crc_reg == crc_unit_pkg::CRC_SEED)
    else $error("frame checksum not seeded");

  a_map_bit_step: assert property ( // RULE_17
    seq_bit_step |=> map_bit_cnt_reg == $past(map_bit_cnt_reg) + 1'b1)
    else $error("map bit counter did not advance");

  a_map_pass_seed: assert property ( // RULE_15
    seq_pass_end |=> (map_state_reg == crc_unit_pkg::MAP_CHECK)
                 ##1 (map_crc_reg == crc_unit_pkg::CRC_SEED) && (map_bit_cnt_reg == '0))
    else $error("map pass not restarted from seed");

  a_map_flag_set: assert property ( // RULE_18
    map_diff |=> map_changed_reg && (map_result_reg == $past(map_crc_reg)))
    else $error("map change not flagged");

  a_map_flag_clear: assert property ( // RULE_19
    status_rd && !map_diff |=> !map_changed_reg)
    else $error("map flag not cleared on status read");

endmodule : crc_unit

/* bench/host_link.sv */
`timescale 1ns/10ps
module host_link (
  // clock
  input  wire logic                 clock,
  // frame traffic towards the checker
  output crc_unit_pkg::rx_frame_s   rx,
  output crc_unit_pkg::tx_frame_s   tx,
  output logic                      status_sent,
  output logic                      status_sent_null
);
  initial begin
    rx = '0;
    tx = '0;
    status_sent = 1'b0;
    status_sent_null = 1'b0;
  end
  // ************************************************************
  // frame driver
  // ************************************************************
  // released data fields carry the inverse of the last value
  task automatic send_frame(input logic [31:0] w0, w1, t0, t1,
                            input logic [15:0] crc, input logic register_write_command);
    crc_unit_pkg::rx_frame_s r;
    crc_unit_pkg::tx_frame_s t;
    r = '0;
    t = '0;
    r.start = 1'b1;
    @(posedge clock);
    rx <= r;
    r.start = 1'b0;
    r.word_valid = 1'b1;
    r.word = w0;
    t.word_valid = 1'b1;
    t.word = t0;
    @(posedge clock);
    rx <= r;
    tx <= t;
    r.word = w1;
    t.word = t1;
    @(posedge clock);
    rx <= r;
    tx <= t;
    r.word_valid = 1'b0;
    r.word = ~w1;
    t.word_valid = 1'b0;
    t.word = ~t1;
    r.crc_valid = 1'b1;
    r.crc = crc;
    @(posedge clock);
    rx <= r;
    tx <= t;
    r.crc_valid = 1'b0;
    r.crc = ~crc;
    r.frame_end = 1'b1;
    r.is_register_write_command = register_write_command;
    @(posedge clock);
    rx <= r;
    r.frame_end = 1'b0;
    r.is_register_write_command = ~register_write_command;
    @(posedge clock);
    rx <= r;
  endtask : send_frame
  task automatic send_status(input logic null_cmd);
    @(posedge clock);
    status_sent <= 1'b1;
    status_sent_null <= null_cmd;
    @(posedge clock);
    status_sent <= 1'b0;
    status_sent_null <= ~null_cmd;
  endtask : send_status
endmodule : host_link

/* bench/test_spi_frame_and_regmap_checksum_value.sv */
`timescale 1ns/10ps
module test_spi_frame_and_regmap_checksum_value;
  logic                      clock;
  logic                      rstn;
  logic                      wr;
  logic                      rd;
  logic                      dci;
  logic [5:0]                addr;
  logic [15:0]               wdata;
  logic [15:0]               rdata;
  logic [15:0]               tx_crc;
  logic [15:0]               map_val;
  crc_unit_pkg::rx_frame_s   rx;
  crc_unit_pkg::tx_frame_s   tx;
  logic                      status_sent;
  logic                      status_sent_null;
  logic                      cmd_execute;
  logic                      cmd_suppress;
  logic                      null_response;
  logic                      comm_err;
  logic                      map_changed;
  int                        n_errors;
  int                        comparisons;
  logic [31:0]               seed;
  logic [15:0]               mirror [0:36];
  logic [15:0]               v;
  logic [15:0]               p;
  logic [5:0]                a;

  crc_unit u_dut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .device_clock_input(dci), .rx(rx), .tx(tx), .status_sent(status_sent),
    .status_sent_null(status_sent_null), .cmd_execute(cmd_execute),
    .cmd_suppress(cmd_suppress), .null_response(null_response), .tx_crc(tx_crc),
    .comm_err(comm_err), .map_changed(map_changed), .regmap_checksum_value(map_val));
  host_link u_host (.clock(clock), .rx(rx), .tx(tx), .status_sent(status_sent),
    .status_sent_null(status_sent_null));

  always #50 clock = ~clock;
  // link clock free-running, phase unrelated to the system clock
  initial begin
    dci = 1'b0;
    #37;
    forever #400 dci = ~dci;
  end
  // ************************************************************
  // expectation helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  function automatic logic [15:0] step(input logic [15:0] c, input logic b,
                                       input logic [15:0] q);
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? q : 16'h0000);
  endfunction : step
  function automatic logic [15:0] crc_words(input logic [31:0] x, y, input logic [15:0] q);
    logic [63:0] d;
    logic [15:0] c;
    d = {x, y};
    c = crc_unit_pkg::CRC_SEED;
    for (int i = 63; i >= 0; i--) c = step(c, d[i], q);
    return c;
  endfunction : crc_words
  function automatic logic [15:0] map_crc(input logic [15:0] q);
    logic [15:0] c;
    c = crc_unit_pkg::CRC_SEED;
    for (int k = 0; k < 37; k++)
      for (int i = 15; i >= 0; i--) c = step(c, mirror[k][i], q);
    return c;
  endfunction : map_crc
  task automatic check(input logic [15:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic wr_reg(input logic [5:0] wa, input logic [15:0] d);
    @(posedge clock);
    addr <= wa;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    if (wa >= 6'h02 && wa <= 6'h26) mirror[wa - 6'h02] = d;
  endtask : wr_reg
  task automatic rd_reg(input logic [5:0] ra, output logic [15:0] d);
    @(posedge clock);
    addr <= ra;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic frame(input logic bad, register_write_command, input logic [3:0] exp);
    logic [31:0] w0, w1, t0, t1;
    w0 = rnd();
    w1 = rnd();
    t0 = rnd();
    t1 = rnd();
    u_host.send_frame(w0, w1, t0, t1, crc_words(w0, w1, p) ^ {15'h0, bad}, register_write_command);
    #1;
    check(16'({cmd_execute, cmd_suppress, null_response, comm_err}), 16'(exp),
          "frame outcome");
    check(tx_crc, crc_words(t0, t1, p), "tx checksum");
  endtask : frame
  task automatic wait_map();
    logic [15:0] e;
    int n;
    e = map_crc(crc_unit_pkg::POLY_CCITT);
    n = 0;
    #1;
    while (map_val !== e && n < 12000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(map_val, e, "map checksum");
    if (n >= 12000) give_verdict();
  endtask : wait_map
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    {wr, rd, addr, wdata} = '0;
    seed = 32'hd71e;
    n_errors = 0;
    comparisons = 0;
    p = crc_unit_pkg::POLY_CCITT;
    foreach (mirror[i]) mirror[i] = 16'h0000;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    check(tx_crc, crc_unit_pkg::CRC_SEED, "tx seed");
    wr_reg(crc_unit_pkg::ADDR_STATUS, 16'hffff);
    wr_reg(crc_unit_pkg::ADDR_REGMAP_CHECKSUM_VALUE, 16'h0000);
    rd_reg(crc_unit_pkg::ADDR_MODE, v);
    check(v, 16'h0000, "mode reset");
    rd_reg(crc_unit_pkg::ADDR_STATUS, v);
    check(v, 16'h0000, "status read-only");
    rd_reg(crc_unit_pkg::ADDR_REGMAP_CHECKSUM_VALUE, v);
    check(v, 16'hffff, "map register read-only");
    rd_reg(6'h30, v);
    check(v, 16'h0000, "unmapped read");
    for (int i = 0; i < 6; i++) begin
      a = 6'h03 + 6'(rnd() % 32'd36);
      wr_reg(a, 16'(rnd()));
      rd_reg(a, v);
      check(v, mirror[a - 6'h02], "register readback");
    end
    $display("test registers done");
    frame(1'b1, 1'b0, 4'b1000);
    for (int k = 0; k < 2; k++) begin
      p = k ? crc_unit_pkg::POLY_ANSI : crc_unit_pkg::POLY_CCITT;
      wr_reg(crc_unit_pkg::ADDR_MODE, k ? 16'h1800 : 16'h1000);
      frame(1'b0, 1'b0, 4'b1000);
      frame(1'b1, 1'b0, 4'b0111);
      rd_reg(crc_unit_pkg::ADDR_STATUS, v);
      check(v & 16'h1000, 16'h1000, "status comm flag");
      frame(1'b0, 1'b0, 4'b1001);
      u_host.send_status(1'b0);
      #1 check(16'(comm_err), 16'h0000, "comm flag clear");
      frame(1'b1, 1'b1, 4'b1011);
      u_host.send_status(1'b1);
    end
    $display("test frames done");
    wr_reg(crc_unit_pkg::ADDR_MODE, 16'h2000);
    wait_map();
    repeat (4800) @(posedge clock);
    #1 check(16'(map_changed), 16'h0000, "map steady");
    rd_reg(crc_unit_pkg::ADDR_REGMAP_CHECKSUM_VALUE, v);
    check(v, map_crc(crc_unit_pkg::POLY_CCITT), "map register");
    for (int k = 0; k < 2; k++) begin
      a = 6'h03 + 6'(rnd() % 32'd36);
      wr_reg(a, ~mirror[a - 6'h02]);
      wait_map();
      repeat (2) @(posedge clock);
      #1 check(16'(map_changed), 16'h0001, "map flag");
      if (k == 0) begin
        rd_reg(crc_unit_pkg::ADDR_STATUS, v);
        check(v & 16'h2000, 16'h2000, "status map flag");
        rd_reg(crc_unit_pkg::ADDR_STATUS, v);
        check(v & 16'h2000, 16'h0000, "status read clear");
      end else begin
        u_host.send_status(1'b1);
        #1 check(16'(map_changed), 16'h0000, "no-op clear");
      end
    end
    $display("test map done");
    give_verdict();
  end
endmodule : test_spi_frame_and_regmap_checksum_value
